// file: shared/spd_pkg.sv
// constants and types for the bank-0 data port and interrupt enable block
package spd_pkg;
	localparam logic [2:0] OFS_DATA = 3'h0;
	localparam logic [2:0] OFS_IE = 3'h1;
	localparam logic [2:0] OFS_EVID = 3'h2;
	localparam logic [7:0] IE_RESET = 8'h00;
	localparam logic [7:0] EVID_RESET = 8'h01;
	localparam int IE_RX = 0;
	localparam int IE_TX = 1;
	localparam int IE_LS = 2;
	localparam int IE_MS = 3;
	localparam int IE_DMA = 4;
	localparam int IE_TXEMP = 5;
	localparam logic [3:0] ID_NONE = 4'h1;
	localparam logic [3:0] ID_LS = 4'h6;
	localparam logic [3:0] ID_RX = 4'h4;
	localparam logic [3:0] ID_TOUT = 4'hc;
	localparam logic [3:0] ID_TX = 4'h2;
	localparam logic [3:0] ID_MS = 4'h0;
	typedef enum logic [1:0] {
		SPD_MODE_NONEXT = 2'b00,
		SPD_MODE_EXT = 2'b01,
		SPD_MODE_CIR = 2'b10
	} spd_mode_t;
endpackage

// file: src/spd_evid.sv
// event identification encoder for non-extended and extended modes
`timescale 1ns/1ps
module spd_evid
	import spd_pkg::*;
(
	input wire spd_mode_t mode,
	input wire logic fifo_en,
	input wire logic [7:0] ie,
	input wire logic ls_p,
	input wire logic rx_p,
	input wire logic tout_p,
	input wire logic tx_p,
	input wire logic ms_p,
	input wire logic dma_p,
	input wire logic temp_p,
	output logic [7:0] evid,
	output logic irq,
	output logic tx_is_top
);
	logic [3:0] code;
	always_comb begin
		code = ID_NONE;
		tx_is_top = 1'b0;
		irq = 1'b0;
		if (mode == SPD_MODE_NONEXT) begin
			// four levels, highest pending enabled source reported
			if (ls_p && ie[IE_LS]) begin
				code = ID_LS;
			end else if (rx_p && ie[IE_RX]) begin
				code = ID_RX;
			end else if (tout_p && ie[IE_RX]) begin
				code = ID_TOUT;
			end else if (tx_p && ie[IE_TX]) begin
				code = ID_TX;
				tx_is_top = 1'b1;
			end else if (ms_p && ie[IE_MS]) begin
				code = ID_MS;
			end
			irq = (code != ID_NONE);
			// bit 0 low while pending
			evid = {fifo_en, fifo_en, 2'b00, code};
		end else begin
			evid = {2'b00, temp_p, dma_p, ms_p, ls_p, tx_p, rx_p | tout_p};
			irq = ((rx_p | tout_p) & ie[IE_RX])
				| (tx_p & ie[IE_TX])
				| (ls_p & ie[IE_LS])
				| (ms_p & ie[IE_MS])
				| (dma_p & ie[IE_DMA])
				| (temp_p & ie[IE_TXEMP]);
		end
	end
endmodule

// file: src/spd_top.sv
// bank-0 data port, interrupt enable and event identification
// Contract
// - data port reads go to receive side, writes to transmit side
// - data read returns holding register or oldest receive fifo entry
// - data write loads holding register or pushes transmit fifo
// - dma cycles always reach the data ports regardless of bank
// - enable bits 5..4 writable only in extended mode, else zero; bits 7..6 always zero
// - reset gives non-extended layout with all enables zero
// - non-extended bit 0 gates high-level 0100 and timeout 1100
// - non-extended bit 1 gates transmit low level 0010
// - non-extended bit 2 gates link status 0110
// - non-extended bit 3 gates modem status 0000
// - extended bit 0 gates receive threshold or timeout
// - extended bit 1 gates transmit below threshold or holding empty
// - extended bit 4 gates dma terminal count
// - extended bit 5 gates transmitter and fifo empty
// - consumer ir bit 2 gates link status or underrun
// - identification read and fifo control write share an address
// - non-extended mode reports highest of four priority levels
// - non-extended identification bit 0 low when pending, resets to one
// - data port at 00h, identification/fifo control at 02h
// - transmit low level clears on top-priority id read or tx write
`timescale 1ns/1ps
module spd_top
	import spd_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic [2:0] addr,
	input wire logic bank0,
	input wire logic cpu_rd,
	input wire logic cpu_wr,
	input wire logic [7:0] wdata,
	input wire logic dma_rd,
	input wire logic dma_wr,
	input wire logic extended_mode_select,
	input wire logic cir_mode,
	input wire logic cir_transmit,
	input wire logic fifo_en,
	input wire logic [7:0] rx_data,
	input wire logic rx_ready,
	input wire logic rx_tout,
	input wire logic tx_low,
	input wire logic link_status_event,
	input wire logic tx_underrun,
	input wire logic modem_status_event,
	input wire logic dma_tc,
	input wire logic dma_enabled,
	input wire logic tx_all_empty,
	output logic [7:0] rdata,
	output logic rx_pop,
	output logic tx_push,
	output logic [7:0] tx_data,
	output logic fifo_control_wr,
	output logic [7:0] fifo_control,
	output logic irq
);
	logic [7:0] interrupt_enable_reg;
	logic [7:0] rdata_next;
	logic [7:0] evid;
	logic irq_next;
	logic tx_is_top;
	logic tx_pend_reg;
	logic dma_pend_reg;
	logic tx_src;
	logic ls_src;
	logic cpu_data_sel;
	logic cpu_evid_rd;
	logic data_rd;
	logic data_wr;
	spd_mode_t mode;

	function automatic logic hit(input logic [2:0] a, input logic [2:0] ofs, input logic b);
		hit = b && (a == ofs);
	endfunction

	always_comb begin
		if (!extended_mode_select) begin
			mode = SPD_MODE_NONEXT;
		end else if (cir_mode) begin
			mode = SPD_MODE_CIR;
		end else begin
			mode = SPD_MODE_EXT;
		end
	end

	assign cpu_data_sel = hit(addr, OFS_DATA, bank0);
	assign cpu_evid_rd = cpu_rd && hit(addr, OFS_EVID, bank0);
	assign data_rd = (cpu_rd && cpu_data_sel) || dma_rd;
	assign data_wr = (cpu_wr && cpu_data_sel) || dma_wr;

	// link status in consumer ir covers underrun during transmission
	assign ls_src = (mode == SPD_MODE_CIR && cir_transmit) ? tx_underrun
		: link_status_event;
	// non-extended transmit source is a latched event, cleared by id read or write
	assign tx_src = (mode == SPD_MODE_NONEXT) ? tx_pend_reg : tx_low;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			interrupt_enable_reg <= IE_RESET;
		end else if (clk_en) begin
			if (!extended_mode_select) begin
				if (cpu_wr && hit(addr, OFS_IE, bank0)) begin
					interrupt_enable_reg <= {4'h0, wdata[3:0]};
				end else begin
					interrupt_enable_reg[7:4] <= 4'h0;
				end
			end else if (cpu_wr && hit(addr, OFS_IE, bank0)) begin
				interrupt_enable_reg <= {2'b00, wdata[5:0]};
			end
		end
	end

	// set wins over clear: rising low level re-arms even in the clear cycle
	logic tx_low_d_reg;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			tx_pend_reg <= 1'b0;
			tx_low_d_reg <= 1'b0;
		end else if (clk_en) begin
			tx_low_d_reg <= tx_low;
			if (tx_low && !tx_low_d_reg) begin
				tx_pend_reg <= 1'b1;
			end else if (data_wr || (cpu_evid_rd && tx_is_top)) begin
				tx_pend_reg <= 1'b0;
			end else if (!tx_low) begin
				tx_pend_reg <= 1'b0;
			end
		end
	end

	// dma event clears on identification read; new count wins
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			dma_pend_reg <= 1'b0;
		end else if (clk_en) begin
			if (dma_tc && dma_enabled) begin
				dma_pend_reg <= 1'b1;
			end else if (cpu_evid_rd) begin
				dma_pend_reg <= 1'b0;
			end
		end
	end

	spd_evid u_evid (
		.mode(mode),
		.fifo_en(fifo_en),
		.ie(interrupt_enable_reg),
		.ls_p(ls_src),
		.rx_p(rx_ready),
		.tout_p(rx_tout && fifo_en),
		.tx_p(tx_src),
		.ms_p(modem_status_event),
		.dma_p(dma_pend_reg),
		.temp_p(tx_all_empty),
		.evid(evid),
		.irq(irq_next),
		.tx_is_top(tx_is_top)
	);

	always_comb begin
		rdata_next = 8'h00;
		if (dma_rd) begin
			rdata_next = rx_data;
		end else if (cpu_rd && bank0) begin
			unique case (addr)
				OFS_DATA: rdata_next = rx_data;
				OFS_IE: rdata_next = interrupt_enable_reg;
				OFS_EVID: rdata_next = evid;
				default: rdata_next = 8'h00;
			endcase
		end
	end

	// registered outputs, one cycle after the strobe
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rdata <= 8'h00;
			rx_pop <= 1'b0;
			tx_push <= 1'b0;
			tx_data <= 8'h00;
			fifo_control_wr <= 1'b0;
			fifo_control <= 8'h00;
			irq <= 1'b0;
		end else if (clk_en) begin
			rdata <= rdata_next;
			rx_pop <= data_rd;
			tx_push <= data_wr;
			if (data_wr) begin
				tx_data <= wdata;
			end
			fifo_control_wr <= cpu_wr && hit(addr, OFS_EVID, bank0);
			if (cpu_wr && hit(addr, OFS_EVID, bank0)) begin
				fifo_control <= wdata;
			end
			irq <= irq_next;
		end
	end
endmodule

// file: verification/spd_top_props.sv
// checker for the bank-0 data port block
`timescale 1ns/1ps
module spd_top_props
	import spd_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic [2:0] addr,
	input wire logic bank0,
	input wire logic cpu_rd,
	input wire logic cpu_wr,
	input wire logic [7:0] wdata,
	input wire logic dma_rd,
	input wire logic dma_wr,
	input wire logic extended_mode_select,
	input wire logic fifo_en,
	input wire logic [7:0] rx_data,
	input wire logic [7:0] rdata,
	input wire logic rx_pop,
	input wire logic tx_push,
	input wire logic [7:0] tx_data,
	input wire logic fifo_control_wr,
	input wire logic [7:0] fifo_control
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic cw;
	logic cr;
	// dma traffic excluded so cpu decode is judged alone
	assign cw = clk_en && cpu_wr && bank0 && !dma_wr;
	assign cr = clk_en && cpu_rd && bank0 && !dma_rd;
	AST_CPU_TX: assert property (cw && addr == OFS_DATA |=> tx_push && tx_data == $past(wdata))
		else $error("cpu data write lost");
	AST_DMA_TX: assert property (clk_en && dma_wr |=> tx_push && tx_data == $past(wdata))
		else $error("dma write lost");
	AST_RX_RD: assert property (clk_en && (dma_rd || cr && addr == OFS_DATA) |=> rx_pop && rdata == $past(rx_data))
		else $error("receive read wrong");
	AST_FCR: assert property (cw && addr == OFS_EVID |=> fifo_control_wr && !tx_push && fifo_control == $past(wdata))
		else $error("fifo control write wrong");
	AST_NO_PUSH: assert property (clk_en && !dma_wr && !(cw && addr == OFS_DATA) |=> !tx_push)
		else $error("push without data write");
	AST_UNMAPPED: assert property (cr && addr > OFS_EVID |=> rdata == 8'h00)
		else $error("unmapped read not zero");
	AST_EVID_NX: assert property (cr && addr == OFS_EVID && !extended_mode_select |=> rdata[5:4] == 2'b00 && rdata[7:6] == {2{$past(fifo_en)}})
		else $error("id upper bits wrong");
	// bench leaves one idle cycle between a write and the following read
	AST_IE_MASK: assert property (cw && addr == OFS_IE && !extended_mode_select
		##2 cr && addr == OFS_IE && !extended_mode_select
		|=> rdata == ($past(wdata, 3) & 8'h0f))
		else $error("upper enables not masked");
	cover property (cw && addr == OFS_IE);
	cover property (cr && addr == OFS_EVID);
	cover property (clk_en && dma_rd);
endmodule
bind spd_top spd_top_props u_props (.*);

// file: verification/spd_src_model.sv
// receive side model: next byte shown only after the current one is taken
`timescale 1ns/1ps
module spd_src_model (
	input wire logic clk,
	input wire logic rx_pop,
	output logic [7:0] rx_data
);
	initial rx_data = 8'h3c;
	always @(posedge clk) begin
		if (rx_pop) begin
			rx_data <= rx_data + 8'h01;
		end
	end
endmodule

// file: verification/test_serial_port_data_and_irq_enable.sv
// self-checking bench for the data port and interrupt enable block
`timescale 1ns/1ps
module test_serial_port_data_and_irq_enable
	import spd_pkg::*;
;
	logic clk = 0, rst_n = 0, clk_en = 1, bank0 = 1, cpu_rd = 0, cpu_wr = 0, dma_rd = 0;
	logic dma_wr = 0, ext = 0, cir = 0, fifo_en = 0, dma_tc = 0, dma_en = 0, cir_tx = 0;
	logic [2:0] addr = 0;
	logic [7:0] wdata = 0, ev = 0, rdata, tx_data, fctl, rx_data;
	logic rx_pop, tx_push, fctl_wr, irq;
	int n_mismatch = 0, samples_checked = 0;
	spd_src_model u_src (.clk(clk), .rx_pop(rx_pop), .rx_data(rx_data));
	spd_top u_dut (.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .addr(addr), .bank0(bank0),
		.cpu_rd(cpu_rd), .cpu_wr(cpu_wr), .wdata(wdata), .dma_rd(dma_rd), .dma_wr(dma_wr),
		.extended_mode_select(ext), .cir_mode(cir), .cir_transmit(cir_tx), .fifo_en(fifo_en),
		.rx_data(rx_data), .rx_ready(ev[0]), .rx_tout(ev[1]), .tx_low(ev[2]),
		.link_status_event(ev[3]), .tx_underrun(ev[6]), .modem_status_event(ev[4]),
		.dma_tc(dma_tc), .dma_enabled(dma_en), .tx_all_empty(ev[5]), .rdata(rdata),
		.rx_pop(rx_pop), .tx_push(tx_push), .tx_data(tx_data), .fifo_control_wr(fctl_wr),
		.fifo_control(fctl), .irq(irq));
	initial begin
		forever #4 clk = ~clk;
	end
	task finish_test;
		$display("checked %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// one strobe cycle; answer is settled at the following falling edge
	task acc(input logic w, input logic [2:0] a, input logic [7:0] d);
		@(negedge clk);
		addr = a;
		wdata = d;
		cpu_wr = w;
		cpu_rd = !w;
		@(negedge clk);
		cpu_wr = 0;
		cpu_rd = 0;
	endtask
	task rd(input logic [2:0] a, input logic [7:0] e);
		acc(1'b0, a, 8'h00);
		chk(rdata, e);
	endtask
	// irq lags its sources by one cycle, so two edges are allowed
	task setev(input logic [7:0] v);
		@(negedge clk);
		ev = v;
		repeat (2) @(negedge clk);
	endtask
	task ext_irq(input logic [7:0] ie, input logic [7:0] v, input logic e);
		acc(1'b1, OFS_IE, ie);
		setev(v);
		chk({7'h00, irq}, {7'h00, e});
		setev(8'h00);
	endtask
	task t_reset;
		rd(OFS_IE, IE_RESET);
		rd(OFS_EVID, EVID_RESET);
		rd(3'h5, 8'h00);
		$display("reset test done");
	endtask
	task t_data;
		acc(1'b1, OFS_DATA, 8'h5a);
		chk({tx_push, 7'h00} | 8'h00, 8'h80);
		chk(tx_data, 8'h5a);
		bank0 = 0;
		dma_wr = 1;
		wdata = 8'hc3;
		@(negedge clk);
		dma_wr = 0;
		chk(tx_data, 8'hc3);
		bank0 = 1;
		rd(OFS_DATA, 8'h3c);
		chk({7'h00, rx_pop}, 8'h01);
		bank0 = 0;
		@(negedge clk);
		dma_rd = 1;
		@(negedge clk);
		dma_rd = 0;
		chk(rdata, 8'h3d);
		bank0 = 1;
		acc(1'b1, OFS_EVID, 8'h81);
		chk(fctl, 8'h81);
		chk({7'h00, fctl_wr}, 8'h01);
		chk(tx_data, 8'hc3);
		$display("data port test done");
	endtask
	task t_ie;
		acc(1'b1, OFS_IE, 8'hff);
		rd(OFS_IE, 8'h0f);
		ext = 1;
		acc(1'b1, OFS_IE, 8'hff);
		rd(OFS_IE, 8'h3f);
		ext = 0;
		rd(OFS_IE, 8'h0f);
		$display("enable test done");
	endtask
	task t_prio;
		fifo_en = 1;
		setev(8'h1f);
		rd(OFS_EVID, 8'hc6);
		chk({7'h00, irq}, 8'h01);
		setev(8'h17);
		rd(OFS_EVID, 8'hc4);
		setev(8'h16);
		rd(OFS_EVID, 8'hcc);
		setev(8'h14);
		rd(OFS_EVID, 8'hc2);
		rd(OFS_EVID, 8'hc0);
		setev(8'h00);
		rd(OFS_EVID, 8'hc1);
		// modem status enable left clear; its event must raise no id or irq
		acc(1'b1, OFS_IE, 8'h07);
		setev(8'h10);
		rd(OFS_EVID, 8'hc1);
		chk({7'h00, irq}, 8'h00);
		setev(8'h00);
		$display("priority test done");
	endtask
	task t_ext;
		ext = 1;
		ext_irq(8'h01, 8'h02, 1'b1);
		ext_irq(8'h02, 8'h04, 1'b1);
		ext_irq(8'h3d, 8'h04, 1'b0);
		ext_irq(8'h20, 8'h20, 1'b1);
		cir = 1;
		cir_tx = 1;
		ext_irq(8'h04, 8'h40, 1'b1);
		ext_irq(8'h04, 8'h08, 1'b0);
		cir_tx = 0;
		ext_irq(8'h04, 8'h08, 1'b1);
		ext_irq(8'h04, 8'h40, 1'b0);
		cir = 0;
		// enables cleared only with no event in flight
		acc(1'b1, OFS_IE, 8'h10);
		dma_en = 1;
		dma_tc = 1;
		@(negedge clk);
		dma_tc = 0;
		@(negedge clk);
		chk({7'h00, irq}, 8'h01);
		rd(OFS_EVID, 8'h10);
		rd(OFS_EVID, 8'h00);
		$display("extended test done");
	endtask
	initial begin
		repeat (8) @(negedge clk);
		rst_n = 1;
		t_reset();
		t_data();
		t_ie();
		t_prio();
		t_ext();
		finish_test();
	end
	initial begin
		repeat (5000) @(posedge clk);
		n_mismatch++;
		finish_test();
	end
endmodule
